// ---- design/cscc_top.sv ----
// Card supply converter control with Avalon-MM register slave and interrupt.
`timescale 1ns/1ps
module cscc_top #(
    parameter int STARTUP_CYCLES = cscc_pkg::STARTUP_CYC,
    parameter int SETTLE_CYCLES = cscc_pkg::SETTLE_CYC
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic CARD_PRESENCE,
    output logic CONVERTER_ENABLE,
    output logic [1:0] CARD_LEVEL,
    output logic CARD_SUPPLY,
    output logic IRQ
);
    cscc_pkg::cscc_state_t state_r, state_nxt;
    logic [cscc_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic on_r, req_r, ack_r;
    logic [1:0] sel_r;
    logic [cscc_pkg::IRQ_W-1:0] ist_r, imask_r, ev;
    logic pres_d_r;

    // Single-cycle answer: waitrequest drops one edge after the request rises.
    wire access = (AVS_READ | AVS_WRITE) & ~ack_r;
    // A write lands only at the edge where waitrequest is sampled low; a request held on writes again every second cycle.
    wire wr = AVS_WRITE & ack_r;
    wire wr_ctrl = wr & (AVS_ADDRESS == cscc_pkg::OFF_CONTROL);
    wire wr_sel = wr & (AVS_ADDRESS == cscc_pkg::OFF_SELECT);
    wire wr_req = wr & (AVS_ADDRESS == cscc_pkg::OFF_REQUEST);
    wire wr_ist = wr & (AVS_ADDRESS == cscc_pkg::OFF_IRQ_STAT);
    wire wr_imask = wr & (AVS_ADDRESS == cscc_pkg::OFF_IRQ_MASK);

    wire ready_flag = (state_r == cscc_pkg::CSCC_READY) | (state_r == cscc_pkg::CSCC_SETTLE)
        | (state_r == cscc_pkg::CSCC_LOADED);
    wire loaded_flag = (state_r == cscc_pkg::CSCC_LOADED);
    wire supply_on = (state_r == cscc_pkg::CSCC_SETTLE) | (state_r == cscc_pkg::CSCC_LOADED);
    wire removed = pres_d_r & ~CARD_PRESENCE;
    // Removal while running forces the converter off in hardware.
    wire auto_off = on_r & ~CARD_PRESENCE & (state_r != cscc_pkg::CSCC_OFF);
    wire on_nxt = auto_off ? 1'b0 : (wr_ctrl ? AVS_WRITEDATA[cscc_pkg::BIT_ON] : on_r);
    // The counter runs down to zero, so it is loaded one short of each wanted interval.
    localparam int STARTUP_LAST = STARTUP_CYCLES - 1;
    localparam int SETTLE_LAST = SETTLE_CYCLES - 1;
    wire [cscc_pkg::CNT_W-1:0] startup_load = STARTUP_LAST[cscc_pkg::CNT_W-1:0];
    wire [cscc_pkg::CNT_W-1:0] settle_load = SETTLE_LAST[cscc_pkg::CNT_W-1:0];

    wire [7:0] ctrl_rd = {on_r, ready_flag, loaded_flag, 5'h00};
    wire [7:0] status_rd = {5'h00, loaded_flag, CARD_PRESENCE, supply_on};
    wire [31:0] rd_mux =
        (AVS_ADDRESS == cscc_pkg::OFF_CONTROL) ? {24'h000000, ctrl_rd} :
        (AVS_ADDRESS == cscc_pkg::OFF_SELECT) ? {30'h00000000, sel_r} :
        (AVS_ADDRESS == cscc_pkg::OFF_REQUEST) ? {31'h00000000, req_r} :
        (AVS_ADDRESS == cscc_pkg::OFF_STATUS) ? {24'h000000, status_rd} :
        (AVS_ADDRESS == cscc_pkg::OFF_IRQ_STAT) ? {28'h0000000, ist_r} :
        (AVS_ADDRESS == cscc_pkg::OFF_IRQ_MASK) ? {28'h0000000, imask_r} : 32'h00000000;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
        ev = '0;
        if (!on_nxt) begin
            state_nxt = cscc_cast(cscc_pkg::CSCC_OFF);
            if (auto_off) begin
                ev[cscc_pkg::IRQ_AUTO_OFF] = 1'b1;
            end
        end else begin
            unique case (state_r)
                cscc_pkg::CSCC_OFF: begin
                    state_nxt = cscc_pkg::CSCC_START;
                    cnt_nxt = startup_load;
                end
                cscc_pkg::CSCC_START: begin
                    if (cnt_r == '0) begin
                        state_nxt = cscc_pkg::CSCC_READY;
                        ev[cscc_pkg::IRQ_READY] = 1'b1;
                    end
                end
                cscc_pkg::CSCC_READY: begin
                    // Request only honoured once ready and card present.
                    if (req_r && CARD_PRESENCE) begin
                        state_nxt = cscc_pkg::CSCC_SETTLE;
                        cnt_nxt = settle_load;
                    end
                end
                cscc_pkg::CSCC_SETTLE: begin
                    if (!req_r || !CARD_PRESENCE) begin
                        state_nxt = cscc_pkg::CSCC_READY;
                    end else if (wr_sel) begin
                        cnt_nxt = settle_load;
                    end else if (cnt_r == '0) begin
                        state_nxt = cscc_pkg::CSCC_LOADED;
                        ev[cscc_pkg::IRQ_VOK] = 1'b1;
                    end
                end
                cscc_pkg::CSCC_LOADED: begin
                    if (!req_r || !CARD_PRESENCE) begin
                        state_nxt = cscc_pkg::CSCC_READY;
                    end else if (wr_sel) begin
                        // A level change while loaded is tolerated but restarts settling.
                        state_nxt = cscc_pkg::CSCC_SETTLE;
                        cnt_nxt = settle_load;
                    end
                end
                default: state_nxt = cscc_pkg::CSCC_OFF;
            endcase
        end
        if (removed) begin
            ev[cscc_pkg::IRQ_REMOVED] = 1'b1;
        end
    end

    function automatic cscc_pkg::cscc_state_t cscc_cast(input cscc_pkg::cscc_state_t s);
        cscc_cast = s;
    endfunction

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_r <= cscc_pkg::CSCC_OFF;
            cnt_r <= '0;
            on_r <= cscc_pkg::CTRL_RESET[cscc_pkg::BIT_ON];
            sel_r <= cscc_pkg::SEL_1V8;
            req_r <= 1'b0;
            pres_d_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            on_r <= on_nxt;
            pres_d_r <= CARD_PRESENCE;
            if (wr_sel && AVS_WRITEDATA[1:0] <= cscc_pkg::SEL_5V) begin
                sel_r <= AVS_WRITEDATA[1:0];
            end
            if (wr_req) begin
                req_r <= AVS_WRITEDATA[0];
            end
        end
    end

    // Set wins over a write-one clear in the same cycle, so no event is lost to a late clear.
    wire [cscc_pkg::IRQ_W-1:0] ist_clr = wr_ist ? AVS_WRITEDATA[cscc_pkg::IRQ_W-1:0] : '0;
    wire [cscc_pkg::IRQ_W-1:0] ist_nxt = (ist_r & ~ist_clr) | ev;

    // Supply is decided from the next state so that the pin and the state move on the same edge.
    wire supply_nxt = (state_nxt == cscc_pkg::CSCC_SETTLE || state_nxt == cscc_pkg::CSCC_LOADED)
        & CARD_PRESENCE;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ist_r <= '0;
            imask_r <= '0;
        end else begin
            ist_r <= ist_nxt;
            if (wr_imask) begin
                imask_r <= AVS_WRITEDATA[cscc_pkg::IRQ_W-1:0];
            end
        end
    end

    // Bus answer: one wait state, then waitrequest low for exactly one cycle with the read data.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack_r <= 1'b0;
            AVS_READDATA <= 32'h00000000;
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            ack_r <= access;
            AVS_WAITREQUEST <= ~access;
            if (access && AVS_READ) begin
                AVS_READDATA <= rd_mux;
            end
        end
    end

    // Converter and card pins are registered so the analog side never sees decode glitches.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            CONVERTER_ENABLE <= 1'b0;
            CARD_LEVEL <= cscc_pkg::SEL_1V8;
            CARD_SUPPLY <= 1'b0;
        end else begin
            CONVERTER_ENABLE <= on_nxt;
            CARD_LEVEL <= sel_r;
            CARD_SUPPLY <= supply_nxt;
        end
    end

    // The interrupt uses the mask as it stood, so a mask write shows one cycle later.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(ist_nxt & imask_r);
        end
    end

    property p_supply_needs_presence;
        @(posedge CLK) disable iff (!RESET_N)
        CARD_SUPPLY |-> $past(CARD_PRESENCE);
    endproperty
    a_supply_needs_presence: assert property (p_supply_needs_presence) else $error("supply without presence");

    property p_off_clears_ready;
        @(posedge CLK) disable iff (!RESET_N)
        !on_r |-> !ready_flag;
    endproperty
    a_off_clears_ready: assert property (p_off_clears_ready) else $error("ready while converter off");

    property p_loaded_implies_ready;
        @(posedge CLK) disable iff (!RESET_N)
        loaded_flag |-> ready_flag && on_r;
    endproperty
    a_loaded_implies_ready: assert property (p_loaded_implies_ready) else $error("loaded without ready");

    property p_auto_off;
        @(posedge CLK) disable iff (!RESET_N)
        auto_off |=> !on_r && !CONVERTER_ENABLE;
    endproperty
    a_auto_off: assert property (p_auto_off) else $error("no power-off on removal");

    property p_req_ignored;
        @(posedge CLK) disable iff (!RESET_N)
        !ready_flag |=> !CARD_SUPPLY;
    endproperty
    a_req_ignored: assert property (p_req_ignored) else $error("supply before ready");

    property p_settle_min;
        @(posedge CLK) disable iff (!RESET_N)
        $rose(state_r == cscc_pkg::CSCC_SETTLE) |-> (cnt_r == settle_load);
    endproperty
    a_settle_min: assert property (p_settle_min) else $error("settle count wrong");

    property p_on_write;
        @(posedge CLK) disable iff (!RESET_N)
        wr_ctrl && !AVS_WRITEDATA[cscc_pkg::BIT_ON] |=> !on_r;
    endproperty
    a_on_write: assert property (p_on_write) else $error("off write ignored");

    property p_ctrl_low_zero;
        @(posedge CLK) disable iff (!RESET_N)
        ctrl_rd[4:0] == 5'h00;
    endproperty
    a_ctrl_low_zero: assert property (p_ctrl_low_zero) else $error("reserved control bits nonzero");

    property p_supply_needs_ready;
        @(posedge CLK) disable iff (!RESET_N)
        CARD_SUPPLY |-> ready_flag;
    endproperty
    a_supply_needs_ready: assert property (p_supply_needs_ready) else $error("supply while not ready");

    property p_enable_follows_on;
        @(posedge CLK) disable iff (!RESET_N)
        CONVERTER_ENABLE == on_r;
    endproperty
    a_enable_follows_on: assert property (p_enable_follows_on) else $error("enable differs from on bit");

    property p_level_legal;
        @(posedge CLK) disable iff (!RESET_N)
        CARD_LEVEL <= cscc_pkg::SEL_5V;
    endproperty
    a_level_legal: assert property (p_level_legal) else $error("card level code illegal");

    property p_loaded_after_settle;
        @(posedge CLK) disable iff (!RESET_N)
        $rose(loaded_flag) |-> $past(state_r == cscc_pkg::CSCC_SETTLE) && ($past(cnt_r) == '0);
    endproperty
    a_loaded_after_settle: assert property (p_loaded_after_settle) else $error("loaded before settling");

    property p_removed_event;
        @(posedge CLK) disable iff (!RESET_N)
        removed |=> ist_r[cscc_pkg::IRQ_REMOVED];
    endproperty
    a_removed_event: assert property (p_removed_event) else $error("removal event lost");

    property p_on_write_one;
        @(posedge CLK) disable iff (!RESET_N)
        wr_ctrl && AVS_WRITEDATA[cscc_pkg::BIT_ON] && !auto_off |=> on_r;
    endproperty
    a_on_write_one: assert property (p_on_write_one) else $error("on write ignored");

    property p_select_refused;
        @(posedge CLK) disable iff (!RESET_N)
        wr_sel && (AVS_WRITEDATA[1:0] > cscc_pkg::SEL_5V) |=> $stable(sel_r);
    endproperty
    a_select_refused: assert property (p_select_refused) else $error("illegal level accepted");
endmodule

// ---- include/cscc_pkg.sv ----
// Constants and types for the card supply converter control block.
package cscc_pkg;
    localparam int CLK_MHZ = 250;
    localparam int SETTLE_US = 20;
    localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
    localparam int STARTUP_US = 200;
    localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;
    localparam int CNT_W = 16;
    localparam logic [7:0] OFF_CONTROL = 8'hef;
    localparam logic [7:0] OFF_SELECT = 8'hf0;
    localparam logic [7:0] OFF_REQUEST = 8'hf1;
    localparam logic [7:0] OFF_STATUS = 8'hf2;
    localparam logic [7:0] OFF_IRQ_STAT = 8'hf3;
    localparam logic [7:0] OFF_IRQ_MASK = 8'hf4;
    localparam int BIT_ON = 7;
    localparam int BIT_READY = 6;
    localparam int BIT_LOADED = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] SEL_1V8 = 2'h0;
    localparam logic [1:0] SEL_3V = 2'h1;
    localparam logic [1:0] SEL_5V = 2'h2;
    localparam int IRQ_W = 4;
    localparam int IRQ_READY = 0;
    localparam int IRQ_VOK = 1;
    localparam int IRQ_REMOVED = 2;
    localparam int IRQ_AUTO_OFF = 3;
    typedef enum logic [4:0] {
        CSCC_OFF = 5'h01,
        CSCC_START = 5'h02,
        CSCC_READY = 5'h04,
        CSCC_SETTLE = 5'h08,
        CSCC_LOADED = 5'h10
    } cscc_state_t;
endpackage

// ---- tb/cscc_card_model.sv ----
// Card presence detector model for the card supply converter bench.
`timescale 1ns/1ps
module cscc_card_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic insert,
    output logic card_presence
);
    logic seen_r;

    // The contact switch passes through two registers, so a level change reaches card_presence two clocks later.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            seen_r <= 1'b0;
            card_presence <= 1'b0;
        end else begin
            seen_r <= insert;
            card_presence <= seen_r;
        end
    end
endmodule

// ---- tb/testbench.sv ----
// Self-checking testbench for the card supply converter control block.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module testbench;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} cscc_row_t;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic waitreq, conv_en, supply, irq, presence;
    logic [1:0] level;
    logic insert = 1'b0;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;
    int t0;
    // Write rows are read back; refused and read-only writes must leave the old value.
    cscc_row_t rows [8] = '{'{1'b0, 8'hef, 32'h0, 32'h0}, '{1'b1, 8'hef, 32'h1f, 32'h0},
        '{1'b1, 8'hf0, 32'h3, 32'h0}, '{1'b1, 8'hee, 32'h55, 32'h0}, '{1'b1, 8'hf1, 32'h1, 32'h1},
        '{1'b0, 8'hf2, 32'h0, 32'h0}, '{1'b1, 8'hf1, 32'h0, 32'h0}, '{1'b1, 8'hf0, 32'h2, 32'h2}};

    always #2 clk = ~clk;

    cscc_top #(.STARTUP_CYCLES(8), .SETTLE_CYCLES(8)) DUT (.CLK(clk), .RESET_N(reset_n), .AVS_ADDRESS(adr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(waitreq),
        .CARD_PRESENCE(presence), .CONVERTER_ENABLE(conv_en), .CARD_LEVEL(level), .CARD_SUPPLY(supply), .IRQ(irq));
    cscc_card_model card (.clk(clk), .reset_n(reset_n), .insert(insert), .card_presence(presence));

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= ~w;
        wdat <= d;
        @(posedge clk);
        while (waitreq !== 1'b0 && k < 50) begin
            @(posedge clk);
            k++;
        end
        if (k == 50) err_total++;
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    // Polls are bounded so a flag that never rises fails the check instead of hanging.
    task automatic poll(input logic [7:0] a, input logic [31:0] m);
        n = 0;
        do begin
            bus(1'b0, a, 32'h0);
            n++;
        end while ((q & m) !== m && n < 100);
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        `CHK({conv_en, supply, irq, waitreq}, 4'h1)
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, 32'h0);
            `CHK(q, rows[i].e)
        end
        `CHK(level, 2'h2)
        insert <= 1'b1;
        bus(1'b1, 8'hf1, 32'h1);
        repeat (4) @(posedge clk);
        `CHK(supply, 1'b0)
        bus(1'b1, 8'hf1, 32'h0);
        bus(1'b1, 8'hf4, 32'hf);
        bus(1'b1, 8'hef, 32'h80);
        poll(8'hef, 32'h40);
        `CHK(q[7:5], 3'h6)
        `CHK({conv_en, irq}, 2'h3)
        bus(1'b1, 8'hf4, 32'h0);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        bus(1'b1, 8'hf4, 32'hf);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        bus(1'b1, 8'hf3, 32'hf);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        bus(1'b1, 8'hf0, 32'h1);
        bus(1'b1, 8'hf1, 32'h1);
        t0 = cyc;
        repeat (2) @(posedge clk);
        `CHK({supply, level}, 3'h5)
        poll(8'hf2, 32'h4);
        `CHK(cyc - t0 >= 8, 1'b1)
        bus(1'b0, 8'hef, 32'h0);
        `CHK(q[5], 1'b1)
        insert <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK(supply, 1'b0)
        poll(8'hf3, 32'hc);
        `CHK({q[3:2], conv_en}, 3'h6)
        bus(1'b0, 8'hef, 32'h0);
        `CHK(q[7:5], 3'h0)
        bus(1'b1, 8'hf1, 32'h0);
        insert <= 1'b1;
        bus(1'b1, 8'hef, 32'h80);
        poll(8'hef, 32'h40);
        bus(1'b1, 8'hef, 32'h0);
        repeat (2) @(posedge clk);
        `CHK(conv_en, 1'b0)
        bus(1'b0, 8'hef, 32'h0);
        `CHK(q[7:6], 2'h0)
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK({conv_en, supply, irq, waitreq}, 4'h1)
        reset_n <= 1'b1;
        bus(1'b0, 8'hef, 32'h0);
        `CHK(q, 32'h0)
        close_out();
    end
endmodule
